//--- design/chan_cfg_map.vh
// Purpose: Field positions, offsets and codes for the channel config block
// Assumes: APB byte addresses, 32-bit words
// Notes: Definitions only
`ifndef CHAN_CFG_MAP_VH
`define CHAN_CFG_MAP_VH

`define NUM_CHAN 4
`define CHAN_BITS 2

`define CFG_PAD_COUNT_ADJUST_EN_BIT 31
`define CFG_START_HI 29
`define CFG_START_LO 24
`define CFG_INV_BIT 23
`define CFG_LEN_HI 21
`define CFG_LEN_LO 16
`define CFG_END_OF_PADFILL_IRQ_EN_BIT 15
`define CFG_PROT_HI 14
`define CFG_PROT_LO 12
`define CFG_MAX_LENGTH_SELECT_HI 11
`define CFG_MAX_LENGTH_SELECT_LO 10
`define CFG_FCS_BIT 9
`define CFG_MSK_THR_BIT 8
`define CFG_MSK_INC_BIT 7
`define CFG_MSK_DEC_BIT 6
`define CFG_WRITABLE 32'hBFBFFFFE
`define CFG_RESET 32'h00000000

`define PROT_TRANSP 3'h0
`define PROT_SS7 3'h1
`define PROT_HDLC16 3'h2
`define PROT_HDLC32 3'h3

`define MAX_LENGTH_SELECT_OFF 2'h0
`define MAX_LENGTH_SELECT_ONE 2'h1
`define MAX_LENGTH_SELECT_TWO 2'h2

`define ADDR_RX_CFG_BASE 12'h000
`define ADDR_TX_CFG_BASE 12'h040
`define ADDR_SEL 12'h080
`define ADDR_IRQ_STAT 12'h084
`define ADDR_IRQ_MASK 12'h088
`define ADDR_LIMITS 12'h08C

`define IRQ_W 5
`define IRQ_EOP 0
`define IRQ_THR 1
`define IRQ_INC 2
`define IRQ_DEC 3
`define IRQ_PROT_BAD 4

`endif

//--- design/channel_config_decode.v
// Purpose: Per channel and direction config words with decoded settings
// Assumes: APB slave, one clock, engine signals synchronous to clk
// Notes: Decode follows the channel/direction picked in the select register
`include "chan_cfg_map.vh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Separate config word per channel per direction
// - Adjust off: pad count ignores zero insertion
// - Adjust on: zero insertion reduces pad count
// - Bits 29:24 give FIFO start index
// - FIFO size is two times (field+1) dwords
// - Invert off: data passes unchanged
// - Transmit end-of-padfill interrupt gated by bit 15
// - Protocol field: transparent, SS7, FCS16, FCS32
// - Length select zero: no length check
// - Length select one/two picks limit
// - FCS bit clear: strip receive, append transmit
// - FCS bit set: keep receive, no append
// - Non-FCS mode disables short message detection
// - SS7 receive threshold interrupt unless bit 8
// - SS7 receive increment interrupt unless bit 7
// - SS7 receive decrement interrupt unless bit 6
module channel_config_decode (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Channel engine events for the selected channel
  input wire pad_load,
  input wire [7:0] pad_load_value,
  input wire pad_sent,
  input wire zero_insert,
  input wire error_threshold_event,
  input wire error_increment_event,
  input wire error_decrement_event,
  input wire rx_byte_strobe,
  input wire rx_frame_end,
  input wire [7:0] tx_data_in,
  input wire [7:0] rx_data_in,
  // Decoded settings
  output reg [5:0] fifo_start_index,
  output reg [7:0] fifo_dwords,
  output reg [7:0] tx_data_out,
  output reg [7:0] rx_data_out,
  output reg [2:0] protocol_sel,
  output reg fcs_strip_rx,
  output reg fcs_append_tx,
  output reg short_message_check_en,
  output reg max_length_error,
  output reg [7:0] pad_fill_count,
  // Interrupt
  output reg irq
);
  reg [31:0] rx_cfg_reg [0:`NUM_CHAN-1];
  reg [31:0] tx_cfg_reg [0:`NUM_CHAN-1];
  reg [`CHAN_BITS:0] sel_reg;
  reg [`IRQ_W-1:0] stat_reg;
  reg [`IRQ_W-1:0] mask_reg;
  reg [31:0] limits_reg;
  reg [`IRQ_W-1:0] stat_next;
  reg [31:0] cfg;
  reg [31:0] rd_next;
  reg hit;
  reg is_tx;
  reg is_ss7;
  reg pad_adjust_en;
  reg [7:0] pad_count_w;
  reg pad_done_w;
  reg too_long_w;
  reg [`IRQ_W-1:0] ev;
  wire access;
  wire wr;
  integer i;

  assign access = psel && penable && pready;
  assign wr = access && pwrite;

  // Word index inside a per-direction bank
  function [`CHAN_BITS-1:0] bank_index;
    input [11:0] a;
    begin
      bank_index = a[`CHAN_BITS+1:2];
    end
  endfunction

  function in_bank;
    input [11:0] a;
    input [11:0] base;
    begin
      in_bank = (a >= base) && (a < base + 12'h004 * `NUM_CHAN);
    end
  endfunction

  // Selected word drives the decode
  always @* begin
    is_tx = sel_reg[`CHAN_BITS];
    if (is_tx)
      cfg = tx_cfg_reg[sel_reg[`CHAN_BITS-1:0]];
    else
      cfg = rx_cfg_reg[sel_reg[`CHAN_BITS-1:0]];
    is_ss7 = (cfg[`CFG_PROT_HI:`CFG_PROT_LO] == `PROT_SS7);
    pad_adjust_en = cfg[`CFG_PAD_COUNT_ADJUST_EN_BIT];
  end

  pad_count_unit u_pad (
    .clk(clk),
    .rst_b(rst_b),
    .adjust_en(pad_adjust_en),
    .load(pad_load),
    .load_value(pad_load_value),
    .pad_sent(pad_sent),
    .zero_insert(zero_insert),
    .count(pad_count_w),
    .done_pulse(pad_done_w)
  );

  len_check_unit u_len (
    .clk(clk),
    .rst_b(rst_b),
    .max_length_select(cfg[`CFG_MAX_LENGTH_SELECT_HI:`CFG_MAX_LENGTH_SELECT_LO]),
    .max_msg_limit_one(limits_reg[15:0]),
    .max_msg_limit_two(limits_reg[31:16]),
    .byte_strobe(rx_byte_strobe),
    .frame_end(rx_frame_end),
    .too_long(too_long_w)
  );

  // SS7 and end-of-padfill events gated by per-channel config bits, then the global mask
  always @* begin
    ev = {`IRQ_W{1'b0}};
    ev[`IRQ_EOP] = is_tx && pad_done_w && cfg[`CFG_END_OF_PADFILL_IRQ_EN_BIT];
    ev[`IRQ_THR] = !is_tx && is_ss7 && error_threshold_event
      && !cfg[`CFG_MSK_THR_BIT];
    ev[`IRQ_INC] = !is_tx && is_ss7 && error_increment_event
      && !cfg[`CFG_MSK_INC_BIT];
    ev[`IRQ_DEC] = !is_tx && is_ss7 && error_decrement_event
      && !cfg[`CFG_MSK_DEC_BIT];
    // Reserved protocol codes flagged rather than trusted
    ev[`IRQ_PROT_BAD] = cfg[`CFG_PROT_HI];
    // Set wins over a write-one clear in the same cycle
    stat_next = stat_reg;
    if (wr && paddr == `ADDR_IRQ_STAT)
      stat_next = stat_reg & ~pwdata[`IRQ_W-1:0];
    stat_next = stat_next | ev;
  end

  // Read mux
  always @* begin
    hit = 1'b1;
    rd_next = 32'h00000000;
    if (in_bank(paddr, `ADDR_RX_CFG_BASE))
      rd_next = rx_cfg_reg[bank_index(paddr)];
    else if (in_bank(paddr, `ADDR_TX_CFG_BASE))
      rd_next = tx_cfg_reg[bank_index(paddr)];
    else if (paddr == `ADDR_SEL)
      rd_next = {{(31-`CHAN_BITS){1'b0}}, sel_reg};
    else if (paddr == `ADDR_IRQ_STAT)
      rd_next = {{(32-`IRQ_W){1'b0}}, stat_reg};
    else if (paddr == `ADDR_IRQ_MASK)
      rd_next = {{(32-`IRQ_W){1'b0}}, mask_reg};
    else if (paddr == `ADDR_LIMITS)
      rd_next = limits_reg;
    else
      hit = 1'b0;
  end

  // APB: one wait state, pready pulses in the second access cycle
  always @(posedge clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && (paddr[1:0] != 2'b00 || !hit);
      if (psel && penable && !pready && !pwrite)
        prdata <= rd_next;
    end
  end

  // Register writes; reserved bits 30, 22 and 0 held at zero
  always @(posedge clk) begin
    if (!rst_b) begin
      for (i = 0; i < `NUM_CHAN; i = i + 1) begin
        rx_cfg_reg[i] <= `CFG_RESET;
        tx_cfg_reg[i] <= `CFG_RESET;
      end
      sel_reg <= {(`CHAN_BITS+1){1'b0}};
      mask_reg <= {`IRQ_W{1'b0}};
      limits_reg <= 32'h00000000;
      stat_reg <= {`IRQ_W{1'b0}};
    end else begin
      stat_reg <= stat_next;
      if (wr && paddr[1:0] == 2'b00) begin
        if (in_bank(paddr, `ADDR_RX_CFG_BASE))
          rx_cfg_reg[bank_index(paddr)] <= pwdata & `CFG_WRITABLE;
        else if (in_bank(paddr, `ADDR_TX_CFG_BASE))
          tx_cfg_reg[bank_index(paddr)] <= pwdata & `CFG_WRITABLE;
        else if (paddr == `ADDR_SEL)
          sel_reg <= pwdata[`CHAN_BITS:0];
        else if (paddr == `ADDR_IRQ_MASK)
          mask_reg <= pwdata[`IRQ_W-1:0];
        else if (paddr == `ADDR_LIMITS)
          limits_reg <= pwdata;
      end
    end
  end

  // Decoded outputs, all registered
  always @(posedge clk) begin
    if (!rst_b) begin
      fifo_start_index <= 6'h00;
      fifo_dwords <= 8'h02;
      tx_data_out <= 8'h00;
      rx_data_out <= 8'h00;
      protocol_sel <= `PROT_TRANSP;
      fcs_strip_rx <= 1'b1;
      fcs_append_tx <= 1'b1;
      short_message_check_en <= 1'b1;
      max_length_error <= 1'b0;
      pad_fill_count <= 8'h00;
      irq <= 1'b0;
    end else begin
      fifo_start_index <= cfg[`CFG_START_HI:`CFG_START_LO];
      fifo_dwords <= {1'b0, cfg[`CFG_LEN_HI:`CFG_LEN_LO], 1'b0}
        + 8'h02;
      // XOR with a zero mask passes data, all-ones mask inverts it
      tx_data_out <= tx_data_in ^ {8{cfg[`CFG_INV_BIT]}};
      rx_data_out <= rx_data_in ^ {8{cfg[`CFG_INV_BIT]}};
      if (cfg[`CFG_PROT_HI])
        protocol_sel <= `PROT_TRANSP;
      else
        protocol_sel <= cfg[`CFG_PROT_HI:`CFG_PROT_LO];
      fcs_strip_rx <= !cfg[`CFG_FCS_BIT];
      fcs_append_tx <= !cfg[`CFG_FCS_BIT];
      short_message_check_en <= !cfg[`CFG_FCS_BIT];
      max_length_error <= !is_tx && too_long_w;
      pad_fill_count <= pad_count_w;
      irq <= |(stat_next & ~mask_reg);
    end
  end
endmodule // channel_config_decode
`default_nettype wire

//--- design/len_check_unit.v
// Purpose: Maximum receive length check for one selected limit
// Assumes: Byte strobes and frame end from the receive engine
// Notes: Counter saturates so long frames never wrap
`include "chan_cfg_map.vh"
`timescale 1ns/1ps
`default_nettype none
module len_check_unit (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Setup
  input wire [1:0] max_length_select,
  input wire [15:0] max_msg_limit_one,
  input wire [15:0] max_msg_limit_two,
  // Receive stream
  input wire byte_strobe,
  input wire frame_end,
  // Result
  output reg too_long
);
  reg [15:0] byte_cnt;
  reg [15:0] limit;
  reg check_on;

  always @* begin
    limit = 16'hFFFF;
    check_on = 1'b0;
    case (max_length_select)
      `MAX_LENGTH_SELECT_ONE: begin
        limit = max_msg_limit_one;
        check_on = 1'b1;
      end
      `MAX_LENGTH_SELECT_TWO: begin
        limit = max_msg_limit_two;
        check_on = 1'b1;
      end
      default: check_on = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      byte_cnt <= 16'h0000;
      too_long <= 1'b0;
    end else if (frame_end) begin
      byte_cnt <= 16'h0000;
      too_long <= 1'b0;
    end else if (byte_strobe) begin
      if (byte_cnt != 16'hFFFF)
        byte_cnt <= byte_cnt + 16'h0001;
      if (check_on && byte_cnt >= limit)
        too_long <= 1'b1;
    end
  end
endmodule // len_check_unit
`default_nettype wire

//--- design/pad_count_unit.v
// Purpose: Pad fill counter with optional zero-insertion adjustment
// Assumes: Load and decrement pulses from the channel engine
// Notes: Counter saturates at zero
`timescale 1ns/1ps
`default_nettype none
module pad_count_unit (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Control
  input wire adjust_en,
  input wire load,
  input wire [7:0] load_value,
  input wire pad_sent,
  input wire zero_insert,
  // Status
  output reg [7:0] count,
  output reg done_pulse
);
  reg [7:0] count_next;
  reg [1:0] dec;

  always @* begin
    dec = 2'd0;
    if (pad_sent)
      dec = dec + 2'd1;
    if (adjust_en && zero_insert)
      dec = dec + 2'd1;
    // Without adjust, zero insertions are ignored
    if (count > {6'h00, dec})
      count_next = count - {6'h00, dec};
    else
      count_next = 8'h00;
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      count <= 8'h00;
      done_pulse <= 1'b0;
    end else if (load) begin
      count <= load_value;
      done_pulse <= 1'b0;
    end else begin
      count <= count_next;
      done_pulse <= (count != 8'h00) && (count_next == 8'h00) && pad_sent;
    end
  end
endmodule // pad_count_unit
`default_nettype wire

//--- tb/apb_host.sv
// Purpose: Host model that loads config words over APB
// Assumes: Slave answers with pready
// Notes: Wait is not capped; only the bench timeout stops a dead slave from hanging it
`timescale 1ns/1ps
`default_nettype none
module apb_host (
  // Clock
  input wire logic clk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] rdata;
  logic err;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for a dead slave
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data flips so a stale value is never mistaken for fresh
    pwdata <= ~d;
    @(posedge clk);
  endtask
endmodule // apb_host
`default_nettype wire

//--- tb/chan_cfg_asserts.sv
// Purpose: Port checks for channel_config_decode
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module chan_cfg_asserts (
  // Clock, reset and bus
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Engine side and decode
  input wire logic pad_load,
  input wire logic pad_sent,
  input wire logic zero_insert,
  input wire logic [7:0] tx_data_in,
  input wire logic [7:0] rx_data_in,
  input wire logic [7:0] tx_data_out,
  input wire logic [7:0] rx_data_out,
  input wire logic [5:0] fifo_start_index,
  input wire logic [7:0] fifo_dwords,
  input wire logic [2:0] protocol_sel,
  input wire logic fcs_strip_rx,
  input wire logic fcs_append_tx,
  input wire logic short_message_check_en,
  input wire logic [7:0] pad_fill_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  AST_WAIT: assert property (s_setup ##1 s_access |=> pready)
    else $error("no answer after one wait state");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ANSWER: assert property (pready |-> $past(psel && penable))
    else $error("pready without access phase");
  AST_FCS: assert property (fcs_append_tx == fcs_strip_rx
    && short_message_check_en == fcs_strip_rx) else $error("fcs split");
  AST_SIZE: assert property (!fifo_dwords[0] && fifo_dwords != 8'h00)
    else $error("fifo size not even");
  AST_PROT: assert property (protocol_sel <= 3'h3)
    else $error("reserved protocol shown");
  // Both paths share one inversion setting, so the two masks must agree
  AST_INV: assert property ((tx_data_out ^ $past(tx_data_in)) ==
    (rx_data_out ^ $past(rx_data_in)) && (tx_data_out ^ $past(tx_data_in))
    inside {8'h00, 8'hFF}) else $error("data path mask wrong");
  // The shown count lags the counter by one cycle, so look one cycle back
  AST_PAD: assert property (!$past(pad_load || pad_sent || zero_insert)
    |=> $stable(pad_fill_count)) else $error("pad count moved");
  AST_START: assert property ($changed(fifo_start_index) |->
    $past(pready) || $past(pready, 2) || $past(pready, 3))
    else $error("start index moved without a write");
endmodule // chan_cfg_asserts
bind channel_config_decode chan_cfg_asserts u_chk (.*);
`default_nettype wire

//--- tb/channel_config_decode_bench.sv
// Purpose: Self-checking bench for channel_config_decode
// Assumes: Host model drives APB, bench drives engine pins
// Notes: Events pulse one cycle each
`include "chan_cfg_map.vh"
`timescale 1ns/1ps
`default_nettype none
module channel_config_decode_bench;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] ev, pad_load_value, tx_data_in, rx_data_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0] fifo_start_index;
  logic [7:0] fifo_dwords, tx_data_out, rx_data_out, pad_fill_count;
  logic [2:0] protocol_sel;
  logic fcs_strip_rx, fcs_append_tx, short_message_check_en;
  logic max_length_error;
  int n_errors = 0, checks_done = 0, cyc = 0;
  channel_config_decode u_dut (.*, .pad_load(ev[7]), .pad_sent(ev[6]),
    .zero_insert(ev[5]), .error_threshold_event(ev[4]),
    .error_increment_event(ev[3]), .error_decrement_event(ev[2]),
    .rx_byte_strobe(ev[1]), .rx_frame_end(ev[0]));
  apb_host u_host (.*);
  task complete_run;
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task pulse(input logic [7:0] m);
    ev <= m;
    tick(1);
    ev <= 8'h00;
    tick(2);
  endtask
  task wcfg(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d);
    tick(2);
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    u_host.xfer(1'b0, a, 32'h0);
    check(u_host.rdata, e);
  endtask
  task t_words;
    rchk(12'h044, 32'h0);
    // All ones shows which bits are forced clear
    wcfg(12'h004, 32'hFFFFFFFF);
    wcfg(12'h044, 32'h00001000);
    rchk(12'h004, 32'hBFBFFFFE);
    rchk(12'h044, 32'h00001000);
    rchk(12'h0F0, 32'h0);
    check(32'(u_host.err), 32'h1);
  endtask
  task t_decode;
    wcfg(12'h000, 32'h3FBF3000);
    tx_data_in <= 8'hA5;
    rx_data_in <= 8'h3C;
    tick(2);
    check(32'(fifo_start_index), 32'h3F);
    check(32'(fifo_dwords), 32'h80);
    check(32'(tx_data_out), 32'h5A);
    check(32'(rx_data_out), 32'hC3);
    check(32'(fcs_append_tx), 32'h1);
    wcfg(12'h000, 32'h00000200);
    check(32'(fifo_dwords), 32'h2);
    check(32'(tx_data_out), 32'hA5);
    check(32'(fcs_strip_rx), 32'h0);
    check(32'(short_message_check_en), 32'h0);
    for (int p = 0; p < 8; p++) begin
      wcfg(12'h000, 32'(p) << 12);
      check(32'(protocol_sel), (p < 4) ? 32'(p) : 32'h0);
    end
    check(32'(irq), 32'h1);
    wcfg(12'h000, 32'h0);
    wcfg(`ADDR_IRQ_STAT, 32'h1F);
    check(32'(irq), 32'h0);
  endtask
  task t_pad;
    wcfg(`ADDR_SEL, 32'h4);
    wcfg(12'h040, 32'h80008000);
    pad_load_value <= 8'h05;
    pulse(8'h80);
    pulse(8'h20);
    check(32'(pad_fill_count), 32'h4);
    wcfg(12'h040, 32'h00008000);
    pulse(8'h20);
    check(32'(pad_fill_count), 32'h4);
    repeat (3) pulse(8'h40);
    check(32'(irq), 32'h0);
    pulse(8'h40);
    check(32'(irq), 32'h1);
    wcfg(`ADDR_IRQ_STAT, 32'h1F);
    wcfg(12'h040, 32'h0);
    pad_load_value <= 8'h01;
    pulse(8'h80);
    pulse(8'h40);
    check(32'(irq), 32'h0);
  endtask
  task t_ss7;
    wcfg(`ADDR_SEL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wcfg(12'h000, 32'h1000);
      pulse(8'h10 >> i);
      check(32'(irq), 32'h1);
      wcfg(`ADDR_IRQ_STAT, 32'h1F);
      wcfg(12'h000, 32'h1000 | (32'h100 >> i));
      pulse(8'h10 >> i);
      check(32'(irq), 32'h0);
    end
    wcfg(`ADDR_IRQ_MASK, 32'h1F);
    wcfg(12'h000, 32'h1000);
    pulse(8'h10);
    check(32'(irq), 32'h0);
    rchk(`ADDR_IRQ_STAT, 32'h2);
    wcfg(`ADDR_IRQ_STAT, 32'h1F);
    wcfg(`ADDR_IRQ_MASK, 32'h0);
  endtask
  task t_len;
    wcfg(`ADDR_LIMITS, 32'h00050003);
    for (int s = 1; s < 3; s++) begin
      pulse(8'h01);
      wcfg(12'h000, 32'(s) << 10);
      repeat (2 * s + 1) pulse(8'h02);
      check(32'(max_length_error), 32'h0);
      pulse(8'h02);
      check(32'(max_length_error), 32'h1);
    end
    pulse(8'h01);
    wcfg(12'h000, 32'h0);
    repeat (6) pulse(8'h02);
    check(32'(max_length_error), 32'h0);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run;
    end
  end
  initial begin
    rst_b = 1'b0;
    ev = 8'h00;
    pad_load_value = 8'h00;
    tx_data_in = 8'h00;
    rx_data_in = 8'h00;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    t_words;
    t_decode;
    t_pad;
    t_ss7;
    t_len;
    complete_run;
  end
endmodule // channel_config_decode_bench
`default_nettype wire
